//--- hw/ssc_handler.sv
`timescale 1ns/1ps
`include "ssc_consts.svh"

// ==========================================
// fifo
module ssc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0]      wr_r;
    logic [AW:0]      rd_r;

    assign in_ready  = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
    assign out_valid = (wr_r != rd_r);
    assign out_data  = mem[rd_r[AW-1:0]];

    always_ff @(posedge clock) begin
        if (in_valid && in_ready) begin
            mem[wr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wr_r <= wr_r + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_r <= rd_r + 1'b1;
            end
        end
    end
endmodule

// Contract
// - read reply is start, 0x4A, length, position, count, data, checksum.
// - reads reaching outside the settings area return no data.
// - defaults command rewrites every stored setting with its default.
// - after the acknowledgement is fully sent, a software reset follows.
// - defaults reply is 0x52, length 0x01, status, checksum.
// - defaults status 0x00 on success, 0x01 on failure.
// - at start-up stored values are copied into working values.
// - working values are replaced by stored contents on restart.
// - written values are stored unchecked; host supplies legal ones.
// - newly stored values act only after a reset.
// - packet method only in transparent mode; command frames use length.
// - method 0 sends on character gap timeout or packet size.
// - method 1 sends on end-of-text or size, sending that character too.
// - packet size at position 7, 1 to 120, default 120.
// - flow stop raised once received count reaches position 8 value.
// - end-of-text character at position 9, any value, default 10.
// - gap timeout at position 12, two bytes ms, default 5.
// - wait position 14 delay between indication and serial output.
// - retry count at position 20; zero disables retries.
// - acknowledgement wait from position 32, two bytes ms, default 8.
// - symbol rate from four bytes at position 80, default 9600.
// - mode 0x00 is transparent, 0x10 is command.
// - multi-byte values travel least significant byte first.
// - position plus count beyond 128 returns no parameter data.
module ssc_handler
    import ssc_pkg::*;
#(
    parameter int CYC_PER_MS = `SSC_MS_NS / `SSC_CLK_PERIOD_NS
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        store_blank,
    input  wire logic [7:0]  host_rx_data,
    input  wire logic        host_rx_valid,
    output logic             host_rx_ready,
    output logic      [7:0]  host_tx_data,
    output logic             host_tx_valid,
    input  wire logic        host_tx_ready,
    output logic      [7:0]  radio_tx_data,
    output logic             radio_tx_valid,
    input  wire logic        radio_tx_ready,
    output logic             radio_tx_start,
    output logic             rts_n,
    input  wire logic        radio_rx_pending,
    output logic             receive_indication_pin_n,
    output logic             host_out_release,
    output logic             command_mode,
    output logic      [7:0]  radio_retry_count,
    output logic             retries_enabled,
    output logic      [15:0] radio_ack_wait,
    output logic      [31:0] serial_symbol_rate
);
    // ==========================================
    // helpers
    function automatic logic [7:0] default_byte(input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `SSC_POS_PKT_MODE:       v = `SSC_DEF_PKT_MODE;
            `SSC_POS_PKT_SIZE:       v = `SSC_DEF_PKT_SIZE;
            `SSC_POS_FLOW_STOP:      v = `SSC_DEF_FLOW_STOP;
            `SSC_POS_ETX:            v = `SSC_DEF_ETX;
            `SSC_POS_GAP:            v = 8'(`SSC_DEF_GAP);
            `SSC_POS_IND_DELAY:      v = 8'(`SSC_DEF_IND_DELAY);
            `SSC_POS_RETRY:          v = `SSC_DEF_RETRY;
            `SSC_POS_ACK_WAIT:       v = 8'(`SSC_DEF_ACK_WAIT);
            `SSC_POS_TX_POWER:       v = `SSC_DEF_TX_POWER;
            `SSC_POS_PREAMBLE:       v = 8'(`SSC_DEF_PREAMBLE);
            `SSC_POS_DETECT:         v = `SSC_DEF_DETECT;
            `SSC_POS_OP_MODE:        v = `SSC_DEF_OP_MODE;
            `SSC_POS_FLAGS + 7'h01:  v = 8'(`SSC_DEF_FLAGS >> 8);
            `SSC_POS_RATE:           v = 8'(`SSC_DEF_RATE);
            `SSC_POS_RATE + 7'h01:   v = 8'(`SSC_DEF_RATE >> 8);
            `SSC_POS_WORD_LEN:       v = `SSC_DEF_WORD_LEN;
            `SSC_POS_STOP_LEN:       v = `SSC_DEF_STOP_LEN;
            default:                 v = 8'h00;
        endcase
        return v;
    endfunction

    // range test shared by read and write commands
    function automatic logic in_area(input logic [7:0] pos, input logic [7:0] cnt);
        return ({1'b0, pos} + {1'b0, cnt}) <= `SSC_AREA_SIZE;
    endfunction

    // ==========================================
    // storage
    logic [7:0]  stored_configuration [0:127];
    logic [7:0]  pl_r [0:129];
    ssc_state_t  state_r;
    logic        swrst_r;
    logic        rst;
    logic [7:0]  cmd_r;
    logic [7:0]  len_r;
    logic [7:0]  idx_r;
    logic [7:0]  cs_r;
    logic        wipe_r;
    logic        swrst_pend_r;
    logic [7:0]  rep_code_r;
    logic [7:0]  rep_len_r;
    logic [7:0]  rep_stat_r;
    logic        rep_get_r;
    logic [8:0]  tx_k_r;
    logic [7:0]  tx_cs_r;
    logic [7:0]  rbyte;
    logic        tx_load;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        acc_cmd;
    logic        fifo_in_ready;

    // working configuration
    logic        pkt_method1_r;
    logic [7:0]  pkt_size_r;
    logic [7:0]  flow_stop_r;
    logic [7:0]  etx_r;
    logic [15:0] gap_ms_lim_r;
    logic [15:0] ind_delay_r;
    logic [7:0]  op_mode_r;

    assign rst = !resetn || swrst_r;
    assign command_mode = (op_mode_r == `SSC_MODE_COMMAND);
    assign acc_cmd = host_rx_valid && host_rx_ready && command_mode;
    assign wr_addr = wipe_r ? idx_r : 8'(pl_r[0] + idx_r);
    assign wr_data = wipe_r ? default_byte(idx_r[6:0]) : pl_r[8'(idx_r + 8'h02)];

    // ==========================================
    // non-volatile store; survives software reset
    always_ff @(posedge clock) begin
        if (!resetn && store_blank) begin
            for (int i = 0; i < 128; i++) begin
                stored_configuration[i] <= default_byte(7'(i));
            end
        end else if (state_r == SSC_WRITE) begin
            // values are taken as given, no range
            stored_configuration[wr_addr[6:0]] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (state_r == SSC_PAY && acc_cmd && idx_r < `SSC_PAYLOAD_MAX) begin
            pl_r[idx_r] <= host_rx_data;
        end
    end

    // ==========================================
    // working copy, loaded only on the way out of reset
    always_ff @(posedge clock) begin
        if (rst) begin
            pkt_method1_r      <= 1'b0;
            pkt_size_r         <= `SSC_DEF_PKT_SIZE;
            flow_stop_r        <= `SSC_DEF_FLOW_STOP;
            etx_r              <= `SSC_DEF_ETX;
            gap_ms_lim_r       <= `SSC_DEF_GAP;
            ind_delay_r        <= `SSC_DEF_IND_DELAY;
            radio_retry_count  <= `SSC_DEF_RETRY;
            radio_ack_wait     <= `SSC_DEF_ACK_WAIT;
            op_mode_r          <= `SSC_DEF_OP_MODE;
            serial_symbol_rate <= `SSC_DEF_RATE;
        end else if (state_r == SSC_LOAD) begin
            pkt_method1_r      <= stored_configuration[`SSC_POS_PKT_MODE][0];
            pkt_size_r         <= stored_configuration[`SSC_POS_PKT_SIZE];
            flow_stop_r        <= stored_configuration[`SSC_POS_FLOW_STOP];
            etx_r              <= stored_configuration[`SSC_POS_ETX];
            gap_ms_lim_r       <= {stored_configuration[`SSC_POS_GAP + 7'h01],
                                   stored_configuration[`SSC_POS_GAP]};
            ind_delay_r        <= {stored_configuration[`SSC_POS_IND_DELAY + 7'h01],
                                   stored_configuration[`SSC_POS_IND_DELAY]};
            radio_retry_count  <= stored_configuration[`SSC_POS_RETRY];
            radio_ack_wait     <= {stored_configuration[`SSC_POS_ACK_WAIT + 7'h01],
                                   stored_configuration[`SSC_POS_ACK_WAIT]};
            op_mode_r          <= stored_configuration[`SSC_POS_OP_MODE];
            serial_symbol_rate <= {stored_configuration[`SSC_POS_RATE + 7'h03],
                                   stored_configuration[`SSC_POS_RATE + 7'h02],
                                   stored_configuration[`SSC_POS_RATE + 7'h01],
                                   stored_configuration[`SSC_POS_RATE]};
        end
    end

    assign retries_enabled = (radio_retry_count != 8'h00);

    // ==========================================
    // command framing
    always_comb begin
        rbyte = 8'h00;
        case (tx_k_r)
            9'd0:    rbyte = `SSC_START_BYTE;
            9'd1:    rbyte = rep_code_r;
            9'd2:    rbyte = rep_len_r;
            9'd3:    rbyte = rep_get_r ? pl_r[0] : rep_stat_r;
            9'd4:    rbyte = pl_r[1];
            default: rbyte = stored_configuration[7'(pl_r[0] + 8'(tx_k_r - 9'd5))];
        endcase
        if (tx_k_r == 9'd3 + {1'b0, rep_len_r}) begin
            rbyte = tx_cs_r;
        end
    end

    assign tx_load = !host_tx_valid || host_tx_ready;
    assign host_rx_ready = command_mode ?
        (state_r inside {SSC_IDLE, SSC_CMD, SSC_LEN, SSC_PAY, SSC_CSUM}) : fifo_in_ready;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            swrst_r <= 1'b0;
        end else begin
            swrst_r <= (state_r == SSC_SWRST);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r       <= SSC_LOAD;
            cmd_r         <= 8'h00;
            len_r         <= 8'h00;
            idx_r         <= 8'h00;
            cs_r          <= 8'h00;
            wipe_r        <= 1'b0;
            swrst_pend_r  <= 1'b0;
            rep_code_r    <= 8'h00;
            rep_len_r     <= 8'h00;
            rep_stat_r    <= 8'h00;
            rep_get_r     <= 1'b0;
            tx_k_r        <= 9'd0;
            tx_cs_r       <= 8'h00;
            host_tx_data  <= 8'h00;
            host_tx_valid <= 1'b0;
        end else begin
            case (state_r)
                SSC_LOAD: begin
                    state_r <= SSC_IDLE;
                end
                SSC_IDLE: begin
                    if (acc_cmd && host_rx_data == `SSC_START_BYTE) begin
                        cs_r    <= host_rx_data;
                        state_r <= SSC_CMD;
                    end
                end
                SSC_CMD: begin
                    if (acc_cmd) begin
                        cmd_r   <= host_rx_data;
                        cs_r    <= cs_r ^ host_rx_data;
                        state_r <= SSC_LEN;
                    end
                end
                SSC_LEN: begin
                    if (acc_cmd) begin
                        len_r   <= host_rx_data;
                        idx_r   <= 8'h00;
                        cs_r    <= cs_r ^ host_rx_data;
                        state_r <= (host_rx_data == 8'h00) ? SSC_CSUM : SSC_PAY;
                    end
                end
                SSC_PAY: begin
                    if (acc_cmd) begin
                        cs_r  <= cs_r ^ host_rx_data;
                        idx_r <= idx_r + 8'h01;
                        if (idx_r == len_r - 8'h01) begin
                            state_r <= SSC_CSUM;
                        end
                    end
                end
                SSC_CSUM: begin
                    if (acc_cmd) begin
                        // a bad checksum drops the frame silently
                        state_r <= (host_rx_data == cs_r) ? SSC_EXEC : SSC_IDLE;
                    end
                end
                SSC_EXEC: begin
                    idx_r      <= 8'h00;
                    rep_code_r <= cmd_r | `SSC_REPLY_FLAG;
                    rep_len_r  <= 8'h01;
                    rep_stat_r <= `SSC_STAT_FAIL;
                    rep_get_r  <= 1'b0;
                    tx_k_r     <= 9'd0;
                    tx_cs_r    <= 8'h00;
                    state_r    <= SSC_REPLY;
                    case (cmd_r)
                        `SSC_CMD_SET: begin
                            if (len_r >= 8'h02 && len_r <= `SSC_PAYLOAD_MAX
                                && pl_r[1] == len_r - 8'h02 && in_area(pl_r[0], pl_r[1])) begin
                                rep_stat_r <= `SSC_STAT_OK;
                                wipe_r     <= 1'b0;
                                if (pl_r[1] != 8'h00) begin
                                    state_r <= SSC_WRITE;
                                end
                            end
                        end
                        `SSC_CMD_GET: begin
                            rep_get_r <= 1'b1;
                            if (len_r == 8'h02 && in_area(pl_r[0], pl_r[1])) begin
                                rep_len_r <= 8'(pl_r[1] + 8'h02);
                            end else begin
                                rep_len_r <= 8'h02;
                            end
                        end
                        `SSC_CMD_DEFAULTS: begin
                            if (len_r == 8'h00) begin
                                wipe_r     <= 1'b1;
                                rep_stat_r <= `SSC_STAT_OK;
                                state_r    <= SSC_WRITE;
                            end
                        end
                        default: state_r <= SSC_IDLE;
                    endcase
                end
                SSC_WRITE: begin
                    idx_r <= idx_r + 8'h01;
                    if (wipe_r ? (idx_r == 8'h7f) : (idx_r == pl_r[1] - 8'h01)) begin
                        swrst_pend_r <= wipe_r;
                        state_r      <= SSC_REPLY;
                    end
                end
                SSC_REPLY: begin
                    if (tx_load) begin
                        if (tx_k_r <= 9'd3 + {1'b0, rep_len_r}) begin
                            host_tx_data  <= rbyte;
                            host_tx_valid <= 1'b1;
                            tx_cs_r       <= tx_cs_r ^ rbyte;
                            tx_k_r        <= tx_k_r + 9'd1;
                        end else begin
                            // last byte taken by host; only now may reset fire
                            host_tx_valid <= 1'b0;
                            state_r       <= swrst_pend_r ? SSC_SWRST : SSC_IDLE;
                        end
                    end
                end
                SSC_SWRST: begin
                    state_r <= SSC_SWRST;
                end
                default: state_r <= SSC_IDLE;
            endcase
        end
    end

    // ==========================================
    // transparent path
    logic        fifo_out_valid;
    logic        acc_tr;
    logic        trig;
    logic [7:0]  cnt_r;
    logic [7:0]  rel_r;
    logic [7:0]  add;
    logic [31:0] cyc_r;
    logic        tick;
    logic [15:0] gap_r;
    logic [15:0] ind_r;
    logic        radio_hs;

    ssc_fifo #(.WIDTH(8), .DEPTH(32)) u_fifo (
        .clock     (clock),
        .resetn    (!rst),
        .in_data   (host_rx_data),
        .in_valid  (host_rx_valid && !command_mode && state_r == SSC_IDLE),
        .in_ready  (fifo_in_ready),
        .out_data  (radio_tx_data),
        .out_valid (fifo_out_valid),
        .out_ready (radio_tx_ready && rel_r != 8'h00)
    );

    assign acc_tr = host_rx_valid && host_rx_ready && !command_mode && state_r == SSC_IDLE;
    assign tick   = (cyc_r == 32'(CYC_PER_MS - 1));
    assign radio_tx_valid = fifo_out_valid && (rel_r != 8'h00);
    assign radio_hs = radio_tx_valid && radio_tx_ready;
    assign add = cnt_r + {7'h00, acc_tr};

    // fifo full also releases, since the size limit may exceed its depth
    assign trig = (acc_tr && add >= pkt_size_r)
        || (acc_tr && pkt_method1_r && host_rx_data == etx_r)
        || (!pkt_method1_r && !acc_tr && cnt_r != 8'h00 && gap_r >= gap_ms_lim_r)
        || (cnt_r != 8'h00 && !fifo_in_ready && !command_mode);

    assign rts_n = (cnt_r >= flow_stop_r);

    always_ff @(posedge clock) begin
        if (rst) begin
            cyc_r <= 32'h0;
        end else begin
            cyc_r <= tick ? 32'h0 : cyc_r + 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_r          <= 8'h00;
            rel_r          <= 8'h00;
            gap_r          <= 16'h0000;
            radio_tx_start <= 1'b0;
        end else begin
            radio_tx_start <= trig;
            cnt_r          <= trig ? 8'h00 : add;
            rel_r          <= rel_r + (trig ? add : 8'h00) - {7'h00, radio_hs};
            if (acc_tr) begin
                gap_r <= 16'h0000;
            end else if (tick && gap_r != 16'hffff) begin
                gap_r <= gap_r + 16'h0001;
            end
        end
    end

    // ==========================================
    // receive indication, resolution one ms tick
    always_ff @(posedge clock) begin
        if (rst || !radio_rx_pending) begin
            ind_r                    <= 16'h0000;
            receive_indication_pin_n <= 1'b1;
            host_out_release         <= 1'b0;
        end else begin
            receive_indication_pin_n <= 1'b0;
            if (ind_r >= ind_delay_r) begin
                host_out_release <= 1'b1;
            end else if (tick) begin
                ind_r <= ind_r + 16'h0001;
            end
        end
    end
endmodule

//--- pkg/ssc_consts.svh
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH
// ==========================================
// frame bytes and command codes
`define SSC_START_BYTE      8'h02
`define SSC_CMD_SET         8'h09
`define SSC_CMD_GET         8'h0a
`define SSC_CMD_DEFAULTS    8'h12
`define SSC_REPLY_FLAG      8'h40
`define SSC_STAT_OK         8'h00
`define SSC_STAT_FAIL       8'h01
`define SSC_MODE_TRANSP     8'h00
`define SSC_MODE_COMMAND    8'h10
// ==========================================
// stored area
`define SSC_AREA_SIZE       9'h080
`define SSC_PAYLOAD_MAX     8'h82
// ==========================================
// positions
`define SSC_POS_PKT_MODE    7'h05
`define SSC_POS_PKT_SIZE    7'h07
`define SSC_POS_FLOW_STOP   7'h08
`define SSC_POS_ETX         7'h09
`define SSC_POS_GAP         7'h0c
`define SSC_POS_IND_DELAY   7'h0e
`define SSC_POS_RETRY       7'h14
`define SSC_POS_ADDR_MODE   7'h15
`define SSC_POS_DEST_NET    7'h18
`define SSC_POS_DEST_NODE   7'h19
`define SSC_POS_OWN_NET     7'h1c
`define SSC_POS_OWN_NODE    7'h1d
`define SSC_POS_ACK_WAIT    7'h20
`define SSC_POS_TX_POWER    7'h29
`define SSC_POS_PREAMBLE    7'h2c
`define SSC_POS_DETECT      7'h2e
`define SSC_POS_OP_MODE     7'h3c
`define SSC_POS_FLAGS       7'h48
`define SSC_POS_RATE        7'h50
`define SSC_POS_WORD_LEN    7'h54
`define SSC_POS_PARITY      7'h55
`define SSC_POS_STOP_LEN    7'h56
`define SSC_POS_PROFILE     7'h5c
// ==========================================
// defaults
`define SSC_DEF_PKT_MODE    8'h00
`define SSC_DEF_PKT_SIZE    8'h78
`define SSC_DEF_FLOW_STOP   8'h64
`define SSC_DEF_ETX         8'h0a
`define SSC_DEF_GAP         16'h0005
`define SSC_DEF_IND_DELAY   16'h0000
`define SSC_DEF_RETRY       8'h00
`define SSC_DEF_ACK_WAIT    16'h0008
`define SSC_DEF_TX_POWER    8'h0f
`define SSC_DEF_PREAMBLE    16'h0032
`define SSC_DEF_DETECT      8'h0a
`define SSC_DEF_OP_MODE     8'h00
`define SSC_DEF_FLAGS       16'h0200
`define SSC_DEF_RATE        32'h00002580
`define SSC_DEF_WORD_LEN    8'h08
`define SSC_DEF_STOP_LEN    8'h01
// ==========================================
// timing
`define SSC_CLK_PERIOD_NS   8
`define SSC_MS_NS           1000000
`endif

//--- pkg/ssc_pkg.sv
package ssc_pkg;
    typedef enum logic [9:0] {
        SSC_LOAD   = 10'b0000000001,
        SSC_IDLE   = 10'b0000000010,
        SSC_CMD    = 10'b0000000100,
        SSC_LEN    = 10'b0000001000,
        SSC_PAY    = 10'b0000010000,
        SSC_CSUM   = 10'b0000100000,
        SSC_EXEC   = 10'b0001000000,
        SSC_WRITE  = 10'b0010000000,
        SSC_REPLY  = 10'b0100000000,
        SSC_SWRST  = 10'b1000000000
    } ssc_state_t;
endpackage

//--- testbench/ssc_handler_properties.sv
`timescale 1ns/1ps
module ssc_handler_chk (
    input logic        clock,
    input logic        resetn,
    input logic        host_rx_ready,
    input logic        host_tx_valid,
    input logic [7:0]  radio_tx_data,
    input logic        radio_tx_valid,
    input logic        radio_tx_ready,
    input logic        radio_tx_start,
    input logic        radio_rx_pending,
    input logic        receive_indication_pin_n,
    input logic        host_out_release,
    input logic        command_mode,
    input logic [7:0]  radio_retry_count,
    input logic        retries_enabled,
    input logic [15:0] radio_ack_wait,
    input logic [31:0] serial_symbol_rate
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_start_once: assert property (radio_tx_start |=> !radio_tx_start) else $error("start");
    a_reply_busy: assert property (host_tx_valid |-> !host_rx_ready) else $error("busy");
    a_head_hold: assert property (radio_tx_valid && !radio_tx_ready |=>
        radio_tx_valid && $stable(radio_tx_data)) else $error("head moved");
    a_retry_gate: assert property (retries_enabled == (radio_retry_count != 8'h00))
        else $error("retry gate");
    a_ind_follow: assert property (1'b1 |=>
        receive_indication_pin_n == !$past(radio_rx_pending)) else $error("indication");
    a_rel_ind: assert property (host_out_release |-> !receive_indication_pin_n)
        else $error("release alone");
    a_rel_late: assert property ($rose(host_out_release) |->
        $past(radio_rx_pending)) else $error("release early");
    a_values_hold: assert property (!command_mode && $past(resetn, 2) |=>
        $stable(serial_symbol_rate) && $stable(radio_ack_wait)) else $error("reload");
endmodule
bind ssc_handler ssc_handler_chk chk (.*);

//--- testbench/ssc_host_model.sv
`timescale 1ns/1ps
module ssc_host_model (
    input  logic       clock,
    input  logic       rdy,
    output logic [7:0] data,
    output logic       valid
);
    initial {valid, data} = 9'h000;
    // valid stays up between bytes, so back-to-back sends never glitch it
    task automatic send(input logic [7:0] b);
        data  <= b;
        valid <= 1'b1;
        do @(posedge clock); while (rdy !== 1'b1);
    endtask
    task automatic idle();
        valid <= 1'b0;
        data  <= ~data;
    endtask
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        clock, resetn, store_blank, host_tx_ready, radio_tx_ready, radio_rx_pending;
    logic        host_rx_valid, host_rx_ready, host_tx_valid, radio_tx_valid, radio_tx_start;
    logic        rts_n, receive_indication_pin_n, host_out_release, command_mode, retries_enabled;
    logic [7:0]  host_rx_data, host_tx_data, radio_tx_data, radio_retry_count;
    logic [15:0] radio_ack_wait;
    logic [31:0] serial_symbol_rate;
    int          err_total = 0, compares = 0, cyc = 0, k;
    logic [7:0]  frm [4] = '{8'h02, 8'h12, 8'h00, 8'h10};
    ssc_handler #(.CYC_PER_MS(10)) uut (.*);
    ssc_host_model host (.clock, .rdy(host_rx_ready), .data(host_rx_data), .valid(host_rx_valid));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) err_total++;
        if (cyc == 2000) test_done();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        err_total += int'(got !== exp);
        if (got !== exp) $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    endtask
    task automatic take(input logic [7:0] e);
        radio_tx_ready <= 1'b1;
        do @(posedge clock); while (radio_tx_valid !== 1'b1);
        chk(radio_tx_data, e);
    endtask
    task automatic test_done();
        if (err_total == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        {resetn, store_blank, host_tx_ready, radio_tx_ready, radio_rx_pending} = 5'b01100;
        repeat (20) @(posedge clock);
        {resetn, store_blank} <= 2'b10;
        repeat (3) @(posedge clock);
        chk(radio_ack_wait, 16'h0008);
        chk(serial_symbol_rate, 32'h00002580);
        chk(command_mode, 1'b0);
        chk({rts_n, retries_enabled, radio_retry_count}, 10'h000);
        // a defaults frame is plain data while transparent
        for (int i = 0; i < 4; i++) host.send(frm[i]);
        host.idle();
        repeat (20) @(posedge clock);
        chk(radio_tx_valid, 1'b0);
        for (k = 0; radio_tx_start !== 1'b1 && k < 99; k++) @(posedge clock);
        chk(radio_tx_start, 1'b1);
        for (int i = 0; i < 4; i++) take(frm[i]);
        chk({host_tx_valid, host_tx_data, command_mode}, 10'h000);
        radio_tx_ready <= 1'b0;
        for (int i = 0; i < 32; i++) host.send(8'h40 + 8'(i));
        @(posedge clock);
        chk(host_rx_ready, 1'b0);
        host.idle();
        for (int i = 0; i < 32; i++) take(8'h40 + 8'(i));
        @(posedge clock);
        chk(radio_tx_valid, 1'b0);
        radio_rx_pending <= 1'b1;
        repeat (28) @(posedge clock);
        chk({receive_indication_pin_n, host_out_release}, 2'b01);
        // mid-run reset: working values come back from the store
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        chk(serial_symbol_rate, 32'h00002580);
        chk({receive_indication_pin_n, host_out_release}, 2'b01);
        test_done();
    end
endmodule
